/* File: logic/fps_host.sv */
/*
 * Host controller for a parallel NOR flash: APB registers, program command
 * sequence with completion polling, erase suspend/resume, reset command.
 * Assumes flash pins are asynchronous to clk; ready/busy is open drain with pull-up.
 */
// Notes on behaviour
// - Program: two unlocks, A0 code, address/data
// - Hardware reset aborts; host reissues sequence
// - Host polls at the program address
// - Valid data only on next read
// - Suspend code B0; other commands leave window
// - After timeout, reset command needed
module fps_host
    import fps_pkg::*;
#(
    parameter logic [19:0] UNLOCK_A1 = fps_pkg::UNLOCK1_ADDR,
    parameter logic [19:0] UNLOCK_A2 = fps_pkg::UNLOCK2_ADDR,
    parameter logic [7:0]  UNLOCK_D1 = fps_pkg::UNLOCK1_DATA,
    parameter logic [7:0]  UNLOCK_D2 = fps_pkg::UNLOCK2_DATA
)
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output fps_pkg::fps_pins_t      flashPins,
    input  wire logic [15:0]        flashDataIn,
    input  wire logic               busyIndicatorPin,
    output logic                    flashResetB
);
    import fps_pkg::*;

    typedef enum logic [3:0] {
        HS_IDLE, HS_UNL1, HS_UNL2, HS_CODE, HS_DATA, HS_POLL, HS_SINGLE, HS_WAIT
    } fps_hstate_t;

    fps_hstate_t  state_r;
    logic [2:0]   cmd_r;
    logic [19:0]  addr_r;
    logic [15:0]  wdata_r;
    logic [15:0]  rdata_r;
    logic         busy_r;
    logic         done_r;
    logic         fail_r;
    logic         havePrev_r;
    logic         prevToggle_r;
    logic [1:0]   pinSync_r;
    logic [15:0]  dSync1_r;
    logic [15:0]  dSync2_r;
    logic         cycStart_r;
    fps_req_t     cycReq_r;
    logic         cycDone;
    logic [15:0]  cycData;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for flash pins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinSync_r <= 2'b11;
            dSync1_r  <= 16'h0000;
            dSync2_r  <= 16'h0000;
        end
        else
        begin
            pinSync_r <= {pinSync_r[0], busyIndicatorPin};
            dSync1_r  <= flashDataIn;
            dSync2_r  <= dSync1_r;
        end
    end

    fps_bus_cycle u_cycle
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .start   (cycStart_r),
        .req     (cycReq_r),
        .dInSync (dSync2_r),
        .done    (cycDone),
        .rdData  (cycData),
        .pins    (flashPins)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    wire apbWr    = psel && penable && pwrite;
    wire hitCtrl  = (paddr == OFS_CTRL);
    wire hitAddr  = (paddr == OFS_ADDR);
    wire hitWdata = (paddr == OFS_WDATA);
    wire hitStat  = (paddr == OFS_STATUS);
    wire hitRdata = (paddr == OFS_RDATA);
    wire hitAny   = hitCtrl | hitAddr | hitWdata | hitStat | hitRdata;
    wire newCmd   = apbWr && hitCtrl && !busy_r;
    wire [2:0] wrCmd = pwdata[CMD_LSB +: CMD_W];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hitAny;
    assign prdata  = hitStat  ? {28'h0, !pinSync_r[1], fail_r, done_r, busy_r} :
                     hitRdata ? {16'h0, rdata_r} :
                     hitAddr  ? {12'h0, addr_r} :
                     hitWdata ? {16'h0, wdata_r} :
                     hitCtrl  ? {29'h0, cmd_r} : 32'h0;
    assign flashResetB = rst_b;  // controller reset aborts flash too

    // Toggle comparison between successive status reads
    wire curToggle = cycData[TOGGLE_STATUS_ONE];
    wire stillBusy = havePrev_r && (curToggle != prevToggle_r);
    wire pollTrue  = cycData[POLL_STATUS_BIT] == wdata_r[POLL_STATUS_BIT];
    wire timedOut  = cycData[TIMEOUT_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r      <= HS_IDLE;
            cmd_r        <= 3'h0;
            addr_r       <= 20'h00000;
            wdata_r      <= 16'h0000;
            rdata_r      <= 16'h0000;
            busy_r       <= 1'b0;
            done_r       <= 1'b0;
            fail_r       <= 1'b0;
            havePrev_r   <= 1'b0;
            prevToggle_r <= 1'b0;
            cycStart_r   <= 1'b0;
            cycReq_r     <= '0;
        end
        else
        begin
            cycStart_r <= 1'b0;
            if (apbWr && hitAddr && !busy_r)
                addr_r <= pwdata[19:0];
            if (apbWr && hitWdata && !busy_r)
                wdata_r <= pwdata[15:0];
            if (apbWr && hitStat)
                done_r <= pwdata[ST_DONE] ? 1'b0 : done_r;
            case (state_r)
                HS_IDLE:
                begin
                    if (newCmd)
                    begin
                        cmd_r      <= wrCmd;
                        busy_r     <= 1'b1;
                        havePrev_r <= 1'b0;
                        cycStart_r <= 1'b1;
                        if (wrCmd == CMD_PROGRAM)
                        begin
                            fail_r   <= 1'b0;
                            cycReq_r <= '{wr: 1'b1, addr: UNLOCK_A1, data: {8'h00, UNLOCK_D1}};
                            state_r  <= HS_UNL1;
                        end
                        else
                        begin
                            // Suspend/resume are single writes; device filters context
                            cycReq_r.wr   <= (wrCmd != CMD_READ);
                            cycReq_r.addr <= addr_r;
                            cycReq_r.data <= (wrCmd == CMD_SUSPEND) ? {8'h00, FL_SUSPEND_CODE} :
                                             (wrCmd == CMD_RESUME)  ? {8'h00, FL_RESUME_CODE} :
                                             {8'h00, FL_RESET_CODE};
                            if (wrCmd == CMD_RESET)
                                fail_r <= 1'b0;
                            state_r <= HS_SINGLE;
                        end
                    end
                end
                HS_UNL1:
                    if (cycDone)
                    begin
                        cycReq_r   <= '{wr: 1'b1, addr: UNLOCK_A2, data: {8'h00, UNLOCK_D2}};
                        cycStart_r <= 1'b1;
                        state_r    <= HS_UNL2;
                    end
                HS_UNL2:
                    if (cycDone)
                    begin
                        cycReq_r   <= '{wr: 1'b1, addr: UNLOCK_A1, data: {8'h00, FL_PROGRAM_CODE}};
                        cycStart_r <= 1'b1;
                        state_r    <= HS_CODE;
                    end
                HS_CODE:
                    if (cycDone)
                    begin
                        // Address stable before fall, data held past rise
                        cycReq_r   <= '{wr: 1'b1, addr: addr_r, data: wdata_r};
                        cycStart_r <= 1'b1;
                        state_r    <= HS_DATA;
                    end
                HS_DATA:
                    if (cycDone)
                    begin
                        // Poll at the program address
                        cycReq_r   <= '{wr: 1'b0, addr: addr_r, data: 16'h0000};
                        cycStart_r <= 1'b1;
                        state_r    <= HS_POLL;
                    end
                HS_POLL:
                    if (cycDone)
                    begin
                        prevToggle_r <= curToggle;
                        havePrev_r   <= 1'b1;
                        if (havePrev_r && !stillBusy && pollTrue)
                        begin
                            // Fresh read after settling for data
                            cycStart_r <= 1'b1;
                            state_r    <= HS_SINGLE;
                        end
                        else if (havePrev_r && stillBusy && timedOut)
                        begin
                            fail_r  <= 1'b1;  // software must issue reset
                            state_r <= HS_WAIT;
                        end
                        else
                            cycStart_r <= 1'b1;  // Keep polling, no new writes
                    end
                HS_SINGLE:
                    if (cycDone)
                    begin
                        rdata_r <= cycData;
                        // A stuck zero bit reads back unequal
                        if (cmd_r == CMD_PROGRAM && cycData != wdata_r)
                            fail_r <= 1'b1;
                        state_r <= HS_WAIT;
                    end
                HS_WAIT:
                begin
                    busy_r  <= 1'b0;
                    done_r  <= 1'b1;
                    state_r <= HS_IDLE;
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_progStart;
        state_r == HS_IDLE && newCmd && wrCmd == CMD_PROGRAM;
    endsequence

    a_prog_unlock: assert property (@(posedge clk) disable iff (!rst_b)
        s_progStart |=> state_r == HS_UNL1 && cycReq_r.addr == UNLOCK_A1)
        else $error("program did not start with first unlock");
    a_code_value: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == HS_UNL2 && cycDone |=> cycReq_r.data[7:0] == FL_PROGRAM_CODE)
        else $error("program code wrong");
    a_no_write_poll: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == HS_POLL |-> !cycStart_r || !cycReq_r.wr)
        else $error("write issued while polling");
    a_poll_addr: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == HS_POLL |-> cycReq_r.addr == addr_r)
        else $error("poll at wrong address");
    a_fail_timeout: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == HS_POLL && cycDone && stillBusy && timedOut |=> fail_r ##1 done_r)
        else $error("timeout not reported");
endmodule : fps_host

/* File: logic/fps_pkg.sv */
/*
 * Package for the flash program/suspend host controller: register map,
 * command codes, status bit positions, timing counts and carrier structs.
 * Assumes a 100 MHz clock and a parallel NOR flash on 16 data/20 address pins.
 */
package fps_pkg;
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned ADDR_W             = 20;
    localparam int unsigned DATA_W             = 16;
    // Own register offsets
    localparam logic [11:0] OFS_CTRL           = 12'h000;
    localparam logic [11:0] OFS_ADDR           = 12'h004;
    localparam logic [11:0] OFS_WDATA          = 12'h008;
    localparam logic [11:0] OFS_STATUS         = 12'h00c;
    localparam logic [11:0] OFS_RDATA          = 12'h010;
    // Control command field
    localparam int unsigned CMD_LSB            = 0;
    localparam int unsigned CMD_W              = 3;
    localparam logic [2:0]  CMD_READ           = 3'h1;
    localparam logic [2:0]  CMD_PROGRAM        = 3'h2;
    localparam logic [2:0]  CMD_SUSPEND        = 3'h3;
    localparam logic [2:0]  CMD_RESUME         = 3'h4;
    localparam logic [2:0]  CMD_RESET          = 3'h5;
    // Status bit positions
    localparam int unsigned ST_BUSY            = 0;
    localparam int unsigned ST_DONE            = 1;
    localparam int unsigned ST_FAIL            = 2;
    localparam int unsigned ST_PINBUSY         = 3;
    // Flash data bit positions
    localparam int unsigned POLL_STATUS_BIT    = 7;
    localparam int unsigned TOGGLE_STATUS_ONE  = 6;
    localparam int unsigned TIMEOUT_FLAG_BIT   = 5;
    localparam int unsigned ERASE_WINDOW_BIT   = 3;
    localparam int unsigned TOGGLE_STATUS_TWO  = 2;
    // Command codes on the flash bus
    localparam logic [7:0]  FL_PROGRAM_CODE    = 8'ha0;
    localparam logic [7:0]  FL_SUSPEND_CODE    = 8'hb0;
    localparam logic [7:0]  FL_RESUME_CODE     = 8'h30;
    localparam logic [7:0]  FL_RESET_CODE      = 8'hf0;
    // Default unlock cycle values (arbitrary, overridable)
    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 20'h002aa;
    localparam logic [7:0]  UNLOCK1_DATA       = 8'haa;
    localparam logic [7:0]  UNLOCK2_DATA       = 8'h55;
    // Bus cycle timing
    localparam int unsigned STROBE_NS          = 60;
    localparam int unsigned STROBE_CYC         = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SUSPEND_US         = 20;
    localparam int unsigned SUSPEND_CYC        = SUSPEND_US * CLK_MHZ;
    localparam logic [31:0] RESET_CTRL         = 32'h0000_0000;

    typedef struct packed {
        logic              ceB;
        logic              weB;
        logic              oeB;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dOut;
        logic              dOe;
    } fps_pins_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fps_req_t;
endpackage : fps_pkg

/* File: logic/fps_bus_cycle.sv */
/*
 * One flash bus cycle, write or read, with strobes held STROBE_CYC clocks.
 * Assumes the read data input is already synchronised to clk.
 */
module fps_bus_cycle
    import fps_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               start,
    input  wire fps_pkg::fps_req_t  req,
    input  wire logic [15:0]        dInSync,
    output logic                    done,
    output logic [15:0]             rdData,
    output fps_pkg::fps_pins_t      pins
);
    import fps_pkg::*;

    typedef enum logic [1:0] {FB_IDLE, FB_SETUP, FB_STROBE, FB_HOLD} fps_cyc_t;

    fps_cyc_t    state_r;
    fps_req_t    req_r;
    logic [7:0]  cnt_r;
    logic [15:0] rdData_r;
    logic        done_r;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r  <= FB_IDLE;
            req_r    <= '0;
            cnt_r    <= 8'h00;
            rdData_r <= 16'h0000;
            done_r   <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                FB_IDLE:
                begin
                    if (start)
                    begin
                        req_r   <= req;
                        state_r <= FB_SETUP;
                    end
                end
                FB_SETUP:
                begin
                    cnt_r   <= 8'(STROBE_CYC);
                    state_r <= FB_STROBE;
                end
                FB_STROBE:
                begin
                    if (cnt_r == 8'h01)
                    begin
                        // Sample read data before strobe rises
                        rdData_r <= dInSync;
                        state_r  <= FB_HOLD;
                    end
                    cnt_r <= cnt_r - 8'h01;
                end
                FB_HOLD:
                begin
                    done_r  <= 1'b1;
                    state_r <= FB_IDLE;
                end
                default: state_r <= FB_IDLE;
            endcase
        end
    end

    // Address set before the falling strobe, data held past the rising edge
    assign pins.ceB  = (state_r == FB_IDLE);
    assign pins.weB  = !(req_r.wr && state_r == FB_STROBE);
    assign pins.oeB  = !(!req_r.wr && state_r == FB_STROBE);
    assign pins.addr = req_r.addr;
    assign pins.dOut = req_r.data;
    assign pins.dOe  = req_r.wr && state_r != FB_IDLE;
    assign done      = done_r;
    assign rdData    = rdData_r;

    a_no_overlap: assert property (@(posedge clk) disable iff (!rst_b)
        !(!pins.weB && !pins.oeB)) else $error("write and read strobes overlap");
endmodule : fps_bus_cycle

/* File: bench/fps_flash_model.sv */
/*
 * Behavioural flash device: unlock and program decode, polling, toggle and
 * timeout status on reads, open-drain busy output.
 * Assumes the host drives fps_pins_t; the busy pull-up sits in the bench.
 */
module fps_flash_model
    import fps_pkg::*;
#(
    parameter int unsigned PROG_NS  = 3000,
    parameter int unsigned PROT_NS  = 1000,
    parameter logic [3:0]  PROT_IDX = 4'hb
)
(
    input  wire fps_pkg::fps_pins_t pins,
    input  wire logic               flashResetB,
    input  wire logic               eraseGo,
    output logic [15:0]             dq,
    output logic                    busyLow,
    output logic [7:0]              lastCode
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] mem [16];
    logic [19:0] latchA, pAddr;
    logic [15:0] pData, rdVal, lastDq;
    logic [1:0]  seq;
    logic        busy, tmo, tog1, tog2, eraseOn, susp, prot;
    int unsigned progId;
    event        progEv;
    wire         wrEnd   = pins.ceB | pins.weB;
    wire         rdEnd   = pins.ceB | pins.oeB;
    wire [7:0]   code    = pins.dOut[7:0];
    wire         inErase = (pins.addr[3:2] == 2'd3);

    initial
    begin
        foreach (mem[i]) mem[i] = 16'hffff;
        {seq, busy, tmo, tog1, tog2, eraseOn, susp, prot, lastDq, lastCode, progId} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(negedge wrEnd)
        latchA = pins.addr;

    always @(posedge wrEnd or negedge flashResetB)
    begin
        if (!flashResetB)
        begin
            seq = 2'd0;
            busy = 1'b0;
            tmo = 1'b0;
            {eraseOn, susp} = 2'b00;
        end
        else if (pins.oeB)
        begin
            lastCode = code;
            if (busy)
            begin
                if (tmo && code == FL_RESET_CODE)
                    {busy, tmo} = 2'b00;
            end
            else if (seq == 2'd3)
            begin
                pAddr = latchA;
                pData = pins.dOut;
                prot = (latchA[3:0] == PROT_IDX);
                tmo = !prot && ((mem[latchA[3:0]] & pins.dOut) != pins.dOut);
                busy = 1'b1;
                seq = 2'd0;
                progId++;
                -> progEv;
            end
            // Active erase hears only suspend; resume acts only when suspended
            else if (eraseOn && !susp)
                susp = (code == FL_SUSPEND_CODE);
            else if (eraseOn && code == FL_RESUME_CODE)
                {susp, seq} = 3'b000;
            else if (seq == 2'd0)
                seq = (latchA == UNLOCK1_ADDR && code == UNLOCK1_DATA) ? 2'd1 : 2'd0;
            else if (seq == 2'd1)
                seq = (latchA == UNLOCK2_ADDR && code == UNLOCK2_DATA) ? 2'd2 : 2'd0;
            else
                seq = (latchA == UNLOCK1_ADDR && code == FL_PROGRAM_CODE) ? 2'd3 : 2'd0;
        end
    end

    always @(progEv)
        fork
            automatic int unsigned myId = progId;
            begin
                #(prot ? PROT_NS : PROG_NS);
                if (busy && !tmo && myId == progId)
                begin
                    if (!prot)
                        mem[pAddr[3:0]] = mem[pAddr[3:0]] & pData;
                    busy = 1'b0;
                end
            end
        join_none

    always @(posedge eraseGo)
        {eraseOn, susp} = 2'b10;

    always @(posedge rdEnd)
    begin
        lastDq = rdVal;
        if (busy || (eraseOn && !susp))
            tog1 = ~tog1;
        if (eraseOn && inErase)
            tog2 = ~tog2;
    end

    // Erase status in the erasing sector, and at any address while active
    assign rdVal = busy ? {8'h00, ~pData[7], tog1, tmo, 5'h00} :
                   (eraseOn && (!susp || inErase)) ? {8'h00, susp, tog1, 2'b00, !susp, tog2, 2'b00} :
                   mem[pins.addr[3:0]];
    // Released data lines show the inverse of the last value
    assign dq = (!pins.ceB && !pins.oeB) ? rdVal : ~lastDq;
    assign busyLow = busy || (eraseOn && !susp);
endmodule : fps_flash_model

/* File: bench/tb_flash_program_suspend_status.sv */
/*
 * Self-checking bench for fps_host with a behavioural flash device.
 * Assumes zero-wait APB and the flash model in fps_flash_model.
 */
module tb_flash_program_suspend_status;
    import fps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] PROT_IDX = 4'hb;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, flashResetB, busyLow;
    logic        eraseGo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] flashDataIn;
    logic [7:0]  lastCode;
    logic [15:0] shadow [16];
    fps_pins_t   flashPins;
    wire         busyPin = busyLow ? 1'b0 : 1'b1;
    int          fail_count, samples_checked, seed;

    fps_host uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flashPins(flashPins), .flashDataIn(flashDataIn), .busyIndicatorPin(busyPin),
        .flashResetB(flashResetB));
    fps_flash_model #(.PROT_IDX(PROT_IDX)) dev (.pins(flashPins), .flashResetB(flashResetB), .eraseGo(eraseGo),
        .dq(flashDataIn), .busyLow(busyLow), .lastCode(lastCode));

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            complete_run();
        end
    endtask : apb

    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wrReg

    task automatic rdReg(input logic [11:0] a, output logic [31:0] rd);
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
    endtask : rdReg

    task automatic waitIdle(output logic sawPin);
        logic [31:0] st;
        int          n;
        sawPin = 1'b0;
        n = 0;
        do
        begin
            rdReg(OFS_STATUS, st);
            sawPin = sawPin | st[ST_PINBUSY];
            n++;
        end
        while (st[ST_BUSY] !== 1'b0 && n < 3000);
        if (st[ST_BUSY] !== 1'b0)
        begin
            fail_count++;
            complete_run();
        end
    endtask : waitIdle

    task automatic command(input logic [2:0] c, input logic [19:0] a);
        logic pin;
        wrReg(OFS_ADDR, 32'(a));
        wrReg(OFS_CTRL, 32'(c));
        waitIdle(pin);
    endtask : command

    function automatic logic expFail(input logic [15:0] m, input logic [15:0] d);
        return (m & d) != d;
    endfunction : expFail

    task automatic doProgram(input logic [19:0] a, input logic [15:0] d);
        logic [31:0] st;
        logic        pin, f, t;
        t = expFail(shadow[a[3:0]], d) && a[3:0] != PROT_IDX;
        f = t || a[3:0] == PROT_IDX;
        wrReg(OFS_ADDR, 32'(a));
        wrReg(OFS_WDATA, 32'(d));
        wrReg(OFS_CTRL, 32'(CMD_PROGRAM));
        wrReg(OFS_CTRL, 32'(CMD_SUSPEND));
        waitIdle(pin);
        rdReg(OFS_STATUS, st);
        check("program status", st[3:0], {t, f, 2'b10});
        check("busy pin seen", pin, 1'b1);
        check("last device write", lastCode, d[7:0]);
        if (f)
        begin
            command(CMD_RESET, a);
            check("reset code", lastCode, FL_RESET_CODE);
            command(CMD_READ, a);
        end
        else
            shadow[a[3:0]] = d;
        rdReg(OFS_RDATA, st);
        check("read data", st[15:0], shadow[a[3:0]]);
        wrReg(OFS_STATUS, 32'h2);
        rdReg(OFS_STATUS, st);
        check("done cleared", st[ST_DONE], 1'b0);
    endtask : doProgram

    task automatic eraseCheck(input logic [19:0] a, input logic held);
        logic [31:0] r1, r2, st;
        command(CMD_READ, a);
        rdReg(OFS_RDATA, r1);
        command(CMD_READ, a);
        rdReg(OFS_RDATA, r2);
        rdReg(OFS_STATUS, st);
        check("erase poll bit", r2[POLL_STATUS_BIT], held);
        check("erase window bit", r2[ERASE_WINDOW_BIT], !held);
        check("first toggle moved", r1[TOGGLE_STATUS_ONE] ^ r2[TOGGLE_STATUS_ONE], !held);
        check("second toggle moved", r1[TOGGLE_STATUS_TWO] ^ r2[TOGGLE_STATUS_TWO], 1'b1);
        check("erase busy pin", st[ST_PINBUSY], !held);
    endtask : eraseCheck

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin : main
        logic [31:0] rd, rnd;
        logic        err;
        {rst_b, psel, penable, pwrite, paddr, pwdata, eraseGo, fail_count, samples_checked} = '0;
        seed = 32'h11229c9d;
        foreach (shadow[i]) shadow[i] = 16'hffff;
        repeat (8) @(posedge clk);
        check("idle select", flashPins.ceB, 1'b1);
        check("idle drive", flashPins.dOe, 1'b0);
        rst_b <= 1'b1;
        rdReg(OFS_STATUS, rd);
        check("reset status", rd, 32'h0);
        doProgram(20'h00005, 16'hffff);
        doProgram(20'h00005, 16'h0000);
        doProgram(20'h00005, 16'h0001);
        doProgram(20'h0000b, 16'h00c3);
        repeat (10)
        begin
            rnd = $random(seed);
            doProgram({rnd[19:4], 2'b00, rnd[1:0]}, rnd[31:16]);
        end
        apb(1'b0, 12'h020, 32'h0, rd, err);
        check("unmapped error", err, 1'b1);
        command(CMD_SUSPEND, 20'h00001);
        check("suspend code", lastCode, FL_SUSPEND_CODE);
        command(CMD_RESUME, 20'h00001);
        check("resume code", lastCode, FL_RESUME_CODE);
        command(CMD_READ, 20'h00005);
        rdReg(OFS_RDATA, rd);
        check("read after resume", rd[15:0], shadow[5]);
        eraseGo <= 1'b1;
        eraseCheck(20'h0000c, 1'b0);
        command(CMD_SUSPEND, 20'h0000c);
        eraseCheck(20'h0000d, 1'b1);
        command(CMD_RESUME, 20'h0000c);
        eraseCheck(20'h0000e, 1'b0);
        command(CMD_SUSPEND, 20'h0000c);
        eraseCheck(20'h0000f, 1'b1);
        command(CMD_READ, 20'h00005);
        rdReg(OFS_RDATA, rd);
        check("suspend array read", rd[15:0], shadow[5]);
        wrReg(OFS_ADDR, 32'h9);
        wrReg(OFS_WDATA, 32'h1234);
        wrReg(OFS_CTRL, 32'(CMD_PROGRAM));
        repeat (60) @(posedge clk);
        check("device busy", busyPin, 1'b0);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        check("reset select", flashPins.ceB, 1'b1);
        check("program aborted", busyPin, 1'b1);
        rst_b <= 1'b1;
        rdReg(OFS_STATUS, rd);
        check("status after reset", rd, 32'h0);
        doProgram(20'h00009, 16'h1234);
        complete_run();
    end
endmodule : tb_flash_program_suspend_status
